// ==== rtcis_chk.sv ====
// Assertion checker of the two-wire slave port
module rtcis_chk
(
  input wire       sys_clk,
  input wire       reset,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out_ff,
  input wire       sda_oe_ff,
  input wire [3:0] reg_addr_ff,
  input wire [7:0] reg_wdata_ff,
  input wire       reg_wr_ff,
  input wire       reg_rd_ff,
  input wire [7:0] reg_rdata,
  input wire       busy_ff,
  input wire       timeout_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // ****
  // Link conditions
  // ****
  // Window allows for the two synchroniser stages
  a_start_opens: assert property (
    $fell(sda_in) && scl_in |-> ##[2:5] busy_ff)
    else $error("start not seen");
  a_stop_closes: assert property (
    $rose(sda_in) && scl_in |-> ##[2:5] !busy_ff)
    else $error("stop not seen");
  a_oe_clock_low: assert property (
    $changed(sda_oe_ff) |-> !$past(scl_in, 2))
    else $error("data moved with clock high");
  a_oe_needs_busy: assert property (
    sda_oe_ff |-> busy_ff)
    else $error("drive outside transaction");
  a_out_zero: assert property (
    sda_out_ff == 1'b0)
    else $error("data driven high");

  // ****
  // Timeout and register side
  // ****
  a_timeout_quiet: assert property (
    timeout_ff && $past(timeout_ff) |-> !sda_oe_ff)
    else $error("drive after timeout");
  a_write_valid: assert property (
    reg_wr_ff |-> busy_ff && !timeout_ff)
    else $error("write out of transaction");
  a_write_pulse: assert property (
    reg_wr_ff |=> !reg_wr_ff)
    else $error("write strobe too long");
  a_read_in_txn: assert property (
    reg_rd_ff |-> busy_ff)
    else $error("read outside transaction");

  c_write: cover property (reg_wr_ff);
  c_read: cover property (reg_rd_ff);
  c_timeout: cover property ($rose(timeout_ff));
endmodule

bind rtcis_slave rtcis_chk u_chk
(
  .sys_clk(sys_clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff),
  .reg_addr_ff(reg_addr_ff), .reg_wdata_ff(reg_wdata_ff),
  .reg_wr_ff(reg_wr_ff), .reg_rd_ff(reg_rd_ff), .reg_rdata(reg_rdata),
  .busy_ff(busy_ff), .timeout_ff(timeout_ff)
);

// ==== rtcis_consts.vh ====
// Constants of the real-time clock two-wire slave port
`ifndef RTCIS_CONSTS_VH
`define RTCIS_CONSTS_VH

// Fixed 7-bit slave address 1010 001
`define RTCIS_SLAVE_ADDR      7'h51
`define RTCIS_PTR_WIDTH       4
`define RTCIS_PTR_RESET       4'h0
`define RTCIS_BYTE_BITS       4'h8
`define RTCIS_READ_IDLE       8'hFF

// Bus timeout: 0.95 s at a 40 MHz clock
`define RTCIS_CLK_HZ          40000000
`define RTCIS_TIMEOUT_MS      950
`define RTCIS_TIMEOUT_CYCLES  ((`RTCIS_CLK_HZ / 1000) * `RTCIS_TIMEOUT_MS)

`endif

// ==== rtcis_master.sv ====
// Bus master model driving the two-wire link
module rtcis_master
(
  output logic scl,
  output logic sda_oe,
  input  wire  sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Long low phase: slave turns the line 75 ns after a fall
  // Callers start on a clock edge; every change lands on an edge
  task automatic cond_start();
  begin
    #50 sda_oe <= 1'b0;
    #75 scl <= 1'b1;
    #50 sda_oe <= 1'b1;
    #50 scl <= 1'b0;
  end
  endtask
  task automatic cond_stop();
  begin
    #50 sda_oe <= 1'b1;
    #75 scl <= 1'b1;
    #50 sda_oe <= 1'b0;
    #200;
  end
  endtask
  // Only pulls low or releases the line
  task automatic xfer_bit(input logic b, output logic r);
  begin
    #50 sda_oe <= !b;
    #75 scl <= 1'b1;
    #50 r = sda;
    #25 scl <= 1'b0;
  end
  endtask
  task automatic xfer_byte(input logic [7:0] d, input logic ak,
                           output logic [7:0] q, output logic a);
    integer i;
  begin
    for (i = 7; i >= 0; i--)
      xfer_bit(d[i], q[i]);
    xfer_bit(ak, a);
  end
  endtask
endmodule

// ==== rtcis_slave.v ====
// Two-wire serial slave port with register pointer and bus timeout
`include "rtcis_consts.vh"

module rtcis_slave
(
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out_ff,
  output reg        sda_oe_ff,
  output reg  [3:0] reg_addr_ff,
  output reg  [7:0] reg_wdata_ff,
  output reg        reg_wr_ff,
  output reg        reg_rd_ff,
  input  wire [7:0] reg_rdata,
  output reg        busy_ff,
  output reg        timeout_ff
);

  // ************************************************************
  // State codes
  // ************************************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_WRITE = 3'h2;
  localparam [2:0] ST_READ  = 3'h3;
  localparam [2:0] ST_IGNORE = 3'h4;

  // ************************************************************
  // Line synchronisation and condition detection
  // ************************************************************
  wire [1:0] line_sync;
  reg        scl_d_ff;
  reg        sda_d_ff;
  wire       scl_s;
  wire       sda_s;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire       to_expired;

  rtcis_sync u_sync
  (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in ({scl_in, sda_in}),
    .sync_out (line_sync)
  );

  assign scl_s    = line_sync[1];
  assign sda_s    = line_sync[0];
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  // Edges of data with clock high are conditions only
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  // ************************************************************
  // Transaction state
  // ************************************************************
  reg [2:0] state_ff;
  reg [3:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg       ack_phase_ff;
  reg       ptr_loaded_ff;
  reg       master_nack_ff;
  reg       in_txn_ff;
  reg       dead_ff;
  reg [3:0] ptr_ff;

  // Timer runs from start to stop, repeated starts included
  rtcis_timeout u_timeout
  (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .run        (in_txn_ff),
    .restart    (start_det & ~in_txn_ff),
    .expired_ff (to_expired)
  );

  function [3:0] ptr_next;
    input [3:0] p;
    begin
      ptr_next = p + 4'h1;
    end
  endfunction

  function addr_match;
    input [7:0] b;
    begin
      addr_match = (b[7:1] == `RTCIS_SLAVE_ADDR);
    end
  endfunction

  // Eighth bit seen: the byte is complete
  function byte_done;
    input [3:0] cnt;
    begin
      byte_done = (cnt == `RTCIS_BYTE_BITS);
    end
  endfunction

  // Open drain: pull low for a zero, release for a one or when muted
  function pull_for;
    input bit_val;
    input muted;
    begin
      pull_for = ~bit_val & ~muted;
    end
  endfunction

  // ************************************************************
  // Byte engine
  // ************************************************************
  // Received byte including the bit sampled this edge
  // In read the own bits are shifted in too; only bit 7 is driven
  wire [7:0] rx_byte;
  assign rx_byte = {shift_ff[6:0], sda_s};

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff       <= ST_IDLE;
      bit_cnt_ff     <= 4'h0;
      shift_ff       <= 8'h0;
      ack_phase_ff   <= 1'b0;
      ptr_loaded_ff  <= 1'b0;
      master_nack_ff <= 1'b0;
      in_txn_ff      <= 1'b0;
      dead_ff        <= 1'b0;
      ptr_ff         <= `RTCIS_PTR_RESET;
      sda_out_ff     <= 1'b0;
      sda_oe_ff      <= 1'b0;
      reg_addr_ff    <= 4'h0;
      reg_wdata_ff   <= 8'h0;
      reg_wr_ff      <= 1'b0;
      reg_rd_ff      <= 1'b0;
    end
    else
    begin
      reg_wr_ff <= 1'b0;
      reg_rd_ff <= 1'b0;
      // Output value stays low; only the enable moves
      sda_out_ff <= 1'b0;
      if (start_det)
      begin
        // Fresh start or repeated start: both begin an address byte
        // A repeated start keeps a timed-out port muted
        state_ff       <= ST_ADDR;
        in_txn_ff      <= 1'b1;
        dead_ff        <= dead_ff & in_txn_ff;
        bit_cnt_ff     <= 4'h0;
        ack_phase_ff   <= 1'b0;
        master_nack_ff <= 1'b0;
        ptr_loaded_ff  <= 1'b0;
        sda_oe_ff      <= 1'b0;
      end
      else if (stop_det)
      begin
        // A stop also lifts a timeout clear
        state_ff  <= ST_IDLE;
        in_txn_ff <= 1'b0;
        dead_ff   <= 1'b0;
        sda_oe_ff <= 1'b0;
      end
      else if (to_expired && !dead_ff && in_txn_ff)
      begin
        // Clear the port; stay mute until the next stop
        // The timer flag lags a stop by a cycle, hence the busy guard
        state_ff  <= ST_IGNORE;
        dead_ff   <= 1'b1;
        sda_oe_ff <= 1'b0;
      end
      else if (state_ff == ST_IDLE || state_ff == ST_IGNORE)
      begin
        sda_oe_ff <= 1'b0;
      end
      else if (scl_rise && !ack_phase_ff)
      begin
        // Sample on clock high
        shift_ff   <= rx_byte;
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
      else if (scl_rise && ack_phase_ff && state_ff == ST_READ)
      begin
        // Ninth clock high: a high line is the master's refusal
        master_nack_ff <= sda_s;
      end
      else if (scl_fall && !ack_phase_ff
               && byte_done(bit_cnt_ff))
      begin
        // Eighth falling edge: release, then acknowledge if receiving
        ack_phase_ff <= 1'b1;
        bit_cnt_ff   <= 4'h0;
        sda_oe_ff    <= 1'b0;
        case (state_ff)
          ST_ADDR:
          begin
            if (addr_match(shift_ff))
            begin
              // Muted after a timeout: no acknowledge on the address
              sda_oe_ff <= ~dead_ff;
              if (shift_ff[0])
              begin
                // Fetch now so bit 7 is ready at the ninth fall
                state_ff    <= ST_READ;
                reg_addr_ff <= ptr_ff;
                reg_rd_ff   <= 1'b1;
              end
              else
              begin
                state_ff <= ST_WRITE;
              end
            end
            else
            begin
              // Not ours: leave the line alone until the next start
              state_ff <= ST_IGNORE;
            end
          end
          ST_WRITE:
          begin
            sda_oe_ff <= ~dead_ff;
            if (dead_ff)
            begin
              // Byte dropped; pointer and registers stay as they were
              ptr_loaded_ff <= 1'b1;
            end
            else if (!ptr_loaded_ff)
            begin
              ptr_ff        <= shift_ff[3:0];
              ptr_loaded_ff <= 1'b1;
            end
            else
            begin
              reg_addr_ff  <= ptr_ff;
              reg_wdata_ff <= shift_ff;
              reg_wr_ff    <= ~dead_ff;
              ptr_ff       <= ptr_next(ptr_ff);
            end
          end
          ST_READ:
          begin
            // Byte sent; advance and fetch the next one
            ptr_ff      <= ptr_next(ptr_ff);
            reg_addr_ff <= ptr_next(ptr_ff);
            reg_rd_ff   <= 1'b1;
          end
          default:
          begin
            state_ff <= ST_IGNORE;
          end
        endcase
      end
      else if (scl_fall && ack_phase_ff)
      begin
        // Ninth falling edge: end acknowledge, maybe drive first bit
        ack_phase_ff <= 1'b0;
        sda_oe_ff    <= 1'b0;
        if (state_ff == ST_READ)
        begin
          if (master_nack_ff)
          begin
            state_ff <= ST_IGNORE;
          end
          else
          begin
            shift_ff  <= dead_ff ? `RTCIS_READ_IDLE : reg_rdata;
            sda_oe_ff <= pull_for(reg_rdata[7], dead_ff);
          end
        end
      end
      else if (scl_fall && state_ff == ST_READ)
      begin
        // Next bit already sits on top after the sampling shift
        sda_oe_ff <= byte_done(bit_cnt_ff) ? 1'b0
                     : pull_for(shift_ff[7], dead_ff);
      end
    end
  end

  // ************************************************************
  // Status outputs
  // ************************************************************
  // One cycle behind the engine so both come straight from flops
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      busy_ff    <= 1'b0;
      timeout_ff <= 1'b0;
    end
    else
    begin
      busy_ff    <= in_txn_ff;
      timeout_ff <= dead_ff;
    end
  end

endmodule

// ==== rtcis_sync.v ====
// Two-stage synchroniser for the clock and data lines
module rtcis_sync
(
  input  wire       sys_clk,
  input  wire       reset,
  input  wire [1:0] async_in,
  output wire [1:0] sync_out
);

  reg [1:0] meta_ff;
  reg [1:0] sync_ff;

  // Bus lines idle high, so both stages reset high
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_ff <= 2'h3;
      sync_ff <= 2'h3;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ==== rtcis_timeout.v ====
// Transaction-length timer for the bus timeout
`include "rtcis_consts.vh"

module rtcis_timeout
#(
  parameter [31:0] LIMIT = `RTCIS_TIMEOUT_CYCLES
)
(
  input  wire sys_clk,
  input  wire reset,
  input  wire run,
  input  wire restart,
  output reg  expired_ff
);

  reg [31:0] count_ff;

  // Counts from the start condition; a repeated start does not restart it
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      count_ff   <= 32'h0;
      expired_ff <= 1'b0;
    end
    else if (restart || !run)
    begin
      count_ff   <= 32'h0;
      expired_ff <= 1'b0;
    end
    else if (count_ff >= LIMIT - 32'h1)
    begin
      expired_ff <= 1'b1;
    end
    else
    begin
      count_ff <= count_ff + 32'h1;
    end
  end

endmodule

// ==== tb_top.sv ====
// Self-checking testbench of the two-wire slave port
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk;
  logic       reset;
  wire        scl;
  wire        m_oe;
  wire        s_out;
  wire        s_oe;
  wire        sda;
  wire  [3:0] addr;
  wire  [7:0] wdata;
  wire  [7:0] rdata;
  wire        wr;
  wire        busy;
  wire        tmo;
  logic [7:0] mem [0:15];
  integer     miscompares = 0;
  integer     total_checks = 0;
  integer     i;

  assign sda = !(m_oe | (s_oe & !s_out));
  assign rdata = mem[addr];
  always @(posedge sys_clk)
  begin
    if (wr)
      mem[addr] <= wdata;
  end
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = !sys_clk;
  end

  rtcis_slave dut
  (
    .sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out_ff(s_out), .sda_oe_ff(s_oe), .reg_addr_ff(addr),
    .reg_wdata_ff(wdata), .reg_wr_ff(wr), .reg_rd_ff(),
    .reg_rdata(rdata), .busy_ff(busy), .timeout_ff(tmo)
  );
  // Short timeout keeps the run brief
  defparam dut.u_timeout.LIMIT = 32'h7D0;
  rtcis_master m (.scl(scl), .sda_oe(m_oe), .sda(sda));

  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
  begin
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, what);
    end
  end
  endtask
  task automatic send(input logic [7:0] d, input logic ek);
    logic [7:0] q;
    logic       a;
  begin
    m.xfer_byte(d, 1'b1, q, a);
    check({7'h00, a}, {7'h00, ek}, "ack");
  end
  endtask
  task automatic recv(input logic [7:0] exp, input logic nak);
    logic [7:0] q;
    logic       a;
  begin
    m.xfer_byte(8'hFF, nak, q, a);
    check(q, exp, "read data");
  end
  endtask
  task automatic complete_run();
  begin
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_write();
  begin
    m.cond_start();
    send(8'hA2, 1'b0);
    send(8'h0E, 1'b0);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    send(8'h33, 1'b0);
    m.cond_stop();
    check(mem[4'hE], 8'h11, "wr E");
    check(mem[4'hF], 8'h22, "wr F");
    check(mem[4'h0], 8'h33, "wr 0");
    check({7'h00, busy}, 8'h00, "busy");
    $display("write test done");
  end
  endtask
  task automatic t_read();
  begin
    m.cond_start();
    send(8'hA2, 1'b0);
    send(8'h0F, 1'b0);
    m.cond_start();
    send(8'hA3, 1'b0);
    recv(8'h22, 1'b0);
    recv(8'h33, 1'b1);
    recv(8'hFF, 1'b1);
    m.cond_stop();
    m.cond_start();
    send(8'hA3, 1'b0);
    recv(8'hC1, 1'b1);
    m.cond_stop();
    $display("read test done");
  end
  endtask
  task automatic t_other();
    logic r;
  begin
    m.cond_start();
    send(8'hA4, 1'b1);
    m.cond_stop();
    m.cond_start();
    send(8'hA2, 1'b0);
    m.xfer_bit(1'b0, r);
    m.xfer_bit(1'b1, r);
    m.cond_stop();
    check({7'h00, busy}, 8'h00, "abort");
    $display("address test done");
  end
  endtask
  task automatic t_timeout();
  begin
    m.cond_start();
    send(8'hA2, 1'b0);
    send(8'h02, 1'b0);
    repeat (2100) @(posedge sys_clk);
    check({7'h00, tmo}, 8'h01, "timeout");
    send(8'h77, 1'b1);
    m.cond_start();
    send(8'hA3, 1'b1);
    recv(8'hFF, 1'b1);
    m.cond_stop();
    check(mem[4'h2], 8'hC2, "kept");
    check({7'h00, tmo}, 8'h00, "cleared");
    m.cond_start();
    send(8'hA2, 1'b0);
    m.cond_stop();
    check({7'h00, tmo}, 8'h00, "resumed");
    $display("timeout test done");
  end
  endtask

  initial
  begin
    for (i = 0; i < 16; i++)
      mem[i] = {4'hC, i[3:0]};
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_write();
    t_read();
    t_other();
    t_timeout();
    complete_run();
  end
  initial
  begin
    #1000000;
    miscompares++;
    complete_run();
  end
endmodule
